/* File: soac_pkg.sv */
// Operation
// - Each lookup gives an action vector only on match, one common layout.
// - No match applies nothing; classification passes through unchanged.
// - Matched actions apply in order first, second, third; later values win.
// - DSCP flag bit 0 set replaces DSCP with six bits from bit 1.
// - Class flag bit 7 set replaces QoS class with three bits from bit 8.
// - Drop flag bit 11 set replaces drop precedence with bit 12.
// - Policy group = (old AND NOT mask) OR (value AND mask), mask 13, value 21.
// - Replace flag bit 40 clear adds bit-41 value to VID, set replaces VID.
// - Select at bit 53 routes filter value at 55: 1 source, 2 destination, 3 both.
// - Select zero gives filter id as zero bit prepended to classified VID.
// - Priority flag bit 68 sets PCP from bit 69 and DEI from bit 72.
// - Pop flag bit 73 passes count at 74, else per-port count used.
// - Custom-key field at 76: bits 1:0 first, 3:2 second; 0 keeps earlier choice, 1 IP, 2 source, 3 off.
// - IP-offset key takes 40 frame bytes from byte position 34.
// - Source-offset key takes 40 frame bytes from byte position 12.
// - Up to two VLAN tags are stripped before key bytes are taken.
// - Sticky hit flag set on every entry match, kept until software clears.
// - Final eight-bit policy group goes to both second-stage lookups.
`default_nettype none

package soac_pkg;
    localparam int ACT_W = 81;
    localparam int DSCP_FLAG = 0;
    localparam int DSCP_NEW = 1;
    localparam int CLS_FLAG = 7;
    localparam int CLS_VAL = 8;
    localparam int DP_FLAG = 11;
    localparam int DP_NEW = 12;
    localparam int PG_MASK = 13;
    localparam int PG_VAL = 21;
    localparam int VID_FLAG = 40;
    localparam int VID_VAL = 41;
    localparam int FSEL = 53;
    localparam int FVAL = 55;
    localparam int PRI_FLAG = 68;
    localparam int PRI_VAL = 69;
    localparam int DEI_NEW = 72;
    localparam int POP_FLAG = 73;
    localparam int POP_VAL = 74;
    localparam int KEY_SEL = 76;
    localparam int HIT_BIT = 80;
    localparam logic [1:0] KEY_OFF = 2'h0;
    localparam logic [1:0] KEY_IP = 2'h1;
    localparam logic [1:0] KEY_SRC = 2'h2;
    localparam int KEY_BYTES = 40;
    localparam int IP_START = 34;
    localparam int SRC_START = 12;
    localparam int TAG_BYTES = 4;
    localparam int NUM_ENTRIES = 64;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_HIT_LO = 8'h08;
    localparam logic [7:0] REG_HIT_HI = 8'h0C;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] CTRL_POP_RESET = 2'h0;
endpackage : soac_pkg

//------------------------------------------------------------
// One lookup's action applied to the running classification
//------------------------------------------------------------
module soac_apply_stage (
    // Lookup result
    input wire logic match,
    input wire logic [soac_pkg::ACT_W-1:0] act,
    // Running classification in
    input wire logic [5:0] dscpIn,
    input wire logic [2:0] clsIn,
    input wire logic dpIn,
    input wire logic [7:0] pgIn,
    input wire logic [11:0] vidIn,
    input wire logic [2:0] pcpIn,
    input wire logic deiIn,
    input wire logic popSetIn,
    input wire logic [1:0] popIn,
    input wire logic srcSetIn,
    input wire logic [12:0] srcFidIn,
    input wire logic dstSetIn,
    input wire logic [12:0] dstFidIn,
    input wire logic [3:0] keySelIn,
    // Running classification out
    output logic [5:0] dscpOut,
    output logic [2:0] clsOut,
    output logic dpOut,
    output logic [7:0] pgOut,
    output logic [11:0] vidOut,
    output logic [2:0] pcpOut,
    output logic deiOut,
    output logic popSetOut,
    output logic [1:0] popOut,
    output logic srcSetOut,
    output logic [12:0] srcFidOut,
    output logic dstSetOut,
    output logic [12:0] dstFidOut,
    output logic [3:0] keySelOut
);
    logic [7:0] pgMask;
    logic [1:0] fidSel;
    logic [12:0] fidVal;
    logic [1:0] k0;
    logic [1:0] k1;
    assign pgMask = act[soac_pkg::PG_MASK +: 8];
    assign fidSel = act[soac_pkg::FSEL +: 2];
    assign fidVal = act[soac_pkg::FVAL +: 13];
    assign k0 = act[soac_pkg::KEY_SEL +: 2];
    assign k1 = act[soac_pkg::KEY_SEL+2 +: 2];

    always_comb begin
        dscpOut = dscpIn;
        clsOut = clsIn;
        dpOut = dpIn;
        pgOut = pgIn;
        vidOut = vidIn;
        pcpOut = pcpIn;
        deiOut = deiIn;
        popSetOut = popSetIn;
        popOut = popIn;
        srcSetOut = srcSetIn;
        srcFidOut = srcFidIn;
        dstSetOut = dstSetIn;
        dstFidOut = dstFidIn;
        keySelOut = keySelIn;
        if (match) begin
            if (act[soac_pkg::DSCP_FLAG])
                dscpOut = act[soac_pkg::DSCP_NEW +: 6];
            if (act[soac_pkg::CLS_FLAG])
                clsOut = act[soac_pkg::CLS_VAL +: 3];
            if (act[soac_pkg::DP_FLAG])
                dpOut = act[soac_pkg::DP_NEW];
            pgOut = (pgIn & ~pgMask) | (act[soac_pkg::PG_VAL +: 8] & pgMask);
            // VID replace or add, modulo 4096
            if (act[soac_pkg::VID_FLAG])
                vidOut = act[soac_pkg::VID_VAL +: 12];
            else
                vidOut = 12'(vidIn + act[soac_pkg::VID_VAL +: 12]);
            if (fidSel[0]) begin
                srcSetOut = 1'b1;
                srcFidOut = fidVal;
            end
            if (fidSel[1]) begin
                dstSetOut = 1'b1;
                dstFidOut = fidVal;
            end
            if (act[soac_pkg::PRI_FLAG]) begin
                pcpOut = act[soac_pkg::PRI_VAL +: 3];
                deiOut = act[soac_pkg::DEI_NEW];
            end
            if (act[soac_pkg::POP_FLAG]) begin
                popSetOut = 1'b1;
                popOut = act[soac_pkg::POP_VAL +: 2];
            end
            // per-lookup key select, code 3 off
            if (k0 != soac_pkg::KEY_OFF)
                keySelOut[1:0] = (k0 == 2'h3) ? soac_pkg::KEY_OFF : k0;
            if (k1 != soac_pkg::KEY_OFF)
                keySelOut[3:2] = (k1 == 2'h3) ? soac_pkg::KEY_OFF : k1;
        end
    end
endmodule : soac_apply_stage

`default_nettype wire

/* File: soac_action_combiner.sv */
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`default_nettype none

module soac_action_combiner (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Lookup results and basic classification
    input wire logic lookupValid,
    input wire logic [2:0] lookupMatch,
    input wire logic [soac_pkg::ACT_W-1:0] action0,
    input wire logic [soac_pkg::ACT_W-1:0] action1,
    input wire logic [soac_pkg::ACT_W-1:0] action2,
    input wire logic [5:0] entryIdx0,
    input wire logic [5:0] entryIdx1,
    input wire logic [5:0] entryIdx2,
    input wire logic [5:0] basicDscp,
    input wire logic [2:0] basicClass,
    input wire logic basicDropPrec,
    input wire logic [7:0] basicPolicyGroup,
    input wire logic [11:0] basicVid,
    input wire logic [2:0] basicPcp,
    input wire logic basicDei,
    // Classification results
    output logic classValid,
    output logic [5:0] classDscp,
    output logic [2:0] classQos,
    output logic classDropPrec,
    output logic [7:0] policyGroup,
    output logic [11:0] classVid,
    output logic [2:0] classPcp,
    output logic classDei,
    output logic [12:0] srcFilterId,
    output logic [12:0] dstFilterId,
    output logic [1:0] tagPopCount,
    output logic [3:0] customKeySelect,
    // Frame byte stream
    input wire logic frameStart,
    input wire logic frameByteValid,
    input wire logic [7:0] frameByte,
    input wire logic [1:0] frameTagCount,
    // Custom keys for the second stage
    output logic keyValid,
    output logic [8*soac_pkg::KEY_BYTES-1:0] customKey0,
    output logic [8*soac_pkg::KEY_BYTES-1:0] customKey1
);
    localparam int KW = 8 * soac_pkg::KEY_BYTES;

    //------------------------------------------------------------
    // Three chained action stages
    //------------------------------------------------------------
    logic [5:0] sDscp [4];
    logic [2:0] sCls [4];
    logic sDp [4];
    logic [7:0] sPg [4];
    logic [11:0] sVid [4];
    logic [2:0] sPcp [4];
    logic sDei [4];
    logic sPopSet [4];
    logic [1:0] sPop [4];
    logic sSrcSet [4];
    logic [12:0] sSrcFid [4];
    logic sDstSet [4];
    logic [12:0] sDstFid [4];
    logic [3:0] sKey [4];
    logic [soac_pkg::ACT_W-1:0] acts [3];

    assign acts[0] = action0;
    assign acts[1] = action1;
    assign acts[2] = action2;
    assign sDscp[0] = basicDscp;
    assign sCls[0] = basicClass;
    assign sDp[0] = basicDropPrec;
    assign sPg[0] = basicPolicyGroup;
    assign sVid[0] = basicVid;
    assign sPcp[0] = basicPcp;
    assign sDei[0] = basicDei;
    assign sPopSet[0] = 1'b0;
    assign sPop[0] = 2'h0;
    assign sSrcSet[0] = 1'b0;
    assign sSrcFid[0] = 13'h0000;
    assign sDstSet[0] = 1'b0;
    assign sDstFid[0] = 13'h0000;
    assign sKey[0] = 4'h0;

    for (genvar g = 0; g < 3; g++) begin : gStage
        soac_apply_stage uStage (
            .match(lookupMatch[g]),
            .act(acts[g]),
            .dscpIn(sDscp[g]),
            .clsIn(sCls[g]),
            .dpIn(sDp[g]),
            .pgIn(sPg[g]),
            .vidIn(sVid[g]),
            .pcpIn(sPcp[g]),
            .deiIn(sDei[g]),
            .popSetIn(sPopSet[g]),
            .popIn(sPop[g]),
            .srcSetIn(sSrcSet[g]),
            .srcFidIn(sSrcFid[g]),
            .dstSetIn(sDstSet[g]),
            .dstFidIn(sDstFid[g]),
            .keySelIn(sKey[g]),
            .dscpOut(sDscp[g+1]),
            .clsOut(sCls[g+1]),
            .dpOut(sDp[g+1]),
            .pgOut(sPg[g+1]),
            .vidOut(sVid[g+1]),
            .pcpOut(sPcp[g+1]),
            .deiOut(sDei[g+1]),
            .popSetOut(sPopSet[g+1]),
            .popOut(sPop[g+1]),
            .srcSetOut(sSrcSet[g+1]),
            .srcFidOut(sSrcFid[g+1]),
            .dstSetOut(sDstSet[g+1]),
            .dstFidOut(sDstFid[g+1]),
            .keySelOut(sKey[g+1])
        );
    end

    //------------------------------------------------------------
    // Registers
    //------------------------------------------------------------
    logic [1:0] portPopCount;
    logic hitEnable;
    logic [15:0] classCount;
    logic [soac_pkg::NUM_ENTRIES-1:0] hitFlags;
    logic awHeld;
    logic wHeld;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic doWrite;
    logic [soac_pkg::NUM_ENTRIES-1:0] hitSet;
    logic [soac_pkg::NUM_ENTRIES-1:0] hitClr;

    assign doWrite = awHeld && wHeld && !s_axi_bvalid;

    //------------------------------------------------------------
    // Classification output
    //------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            classValid <= 1'b0;
            classDscp <= 6'h00;
            classQos <= 3'h0;
            classDropPrec <= 1'b0;
            policyGroup <= 8'h00;
            classVid <= 12'h000;
            classPcp <= 3'h0;
            classDei <= 1'b0;
            srcFilterId <= 13'h0000;
            dstFilterId <= 13'h0000;
            tagPopCount <= 2'h0;
            customKeySelect <= 4'h0;
        end else begin
            classValid <= lookupValid;
            if (lookupValid) begin
                classDscp <= sDscp[3];
                classQos <= sCls[3];
                classDropPrec <= sDp[3];
                policyGroup <= sPg[3];
                classVid <= sVid[3];
                classPcp <= sPcp[3];
                classDei <= sDei[3];
                srcFilterId <= sSrcSet[3] ? sSrcFid[3] : {1'b0, sVid[3]};
                dstFilterId <= sDstSet[3] ? sDstFid[3] : {1'b0, sVid[3]};
                tagPopCount <= sPopSet[3] ? sPop[3] : portPopCount;
                customKeySelect <= sKey[3];
            end
        end
    end

    //------------------------------------------------------------
    // Entry hit flags
    //------------------------------------------------------------
    always_comb begin
        hitSet = '0;
        hitClr = '0;
        if (lookupValid && hitEnable) begin
            if (lookupMatch[0])
                hitSet[entryIdx0] = 1'b1;
            if (lookupMatch[1])
                hitSet[entryIdx1] = 1'b1;
            if (lookupMatch[2])
                hitSet[entryIdx2] = 1'b1;
        end
        if (doWrite && awAddr == soac_pkg::REG_HIT_LO)
            hitClr[31:0] = wData;
        if (doWrite && awAddr == soac_pkg::REG_HIT_HI)
            hitClr[63:32] = wData;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            hitFlags <= '0;
        else
            hitFlags <= (hitFlags & ~hitClr) | hitSet;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            classCount <= 16'h0000;
        else if (lookupValid)
            classCount <= classCount + 16'h0001;
    end

    //------------------------------------------------------------
    // AXI4-Lite write side
    //------------------------------------------------------------
    assign awHeld = !s_axi_awready;
    assign wHeld = !s_axi_wready;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            awAddr <= 8'h00;
            wData <= 32'h00000000;
            wStrb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= soac_pkg::RESP_OK;
        end else begin
            if (s_axi_awvalid && !awHeld) begin
                s_axi_awready <= 1'b0;
                awAddr <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && !wHeld) begin
                s_axi_wready <= 1'b0;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awAddr == soac_pkg::REG_CTRL
                    || awAddr == soac_pkg::REG_STATUS
                    || awAddr == soac_pkg::REG_HIT_LO
                    || awAddr == soac_pkg::REG_HIT_HI) ? soac_pkg::RESP_OK
                    : soac_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            portPopCount <= soac_pkg::CTRL_POP_RESET;
            hitEnable <= 1'b1;
        end else if (doWrite && awAddr == soac_pkg::REG_CTRL) begin
            if (wStrb[0])
                portPopCount <= wData[1:0];
            if (wStrb[1])
                hitEnable <= wData[8];
        end
    end

    //------------------------------------------------------------
    // AXI4-Lite read side
    //------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= soac_pkg::RESP_OK;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= soac_pkg::RESP_OK;
                unique case ({s_axi_araddr[7:2], 2'h0})
                    soac_pkg::REG_CTRL:
                        s_axi_rdata <= {23'h000000, hitEnable, 6'h00, portPopCount};
                    soac_pkg::REG_STATUS:
                        s_axi_rdata <= {16'h0000, classCount};
                    soac_pkg::REG_HIT_LO:
                        s_axi_rdata <= hitFlags[31:0];
                    soac_pkg::REG_HIT_HI:
                        s_axi_rdata <= hitFlags[63:32];
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= soac_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------
    // Custom key extraction
    //------------------------------------------------------------
    logic [7:0] bytePos;
    logic [3:0] tagBytes;
    logic [7:0] ipFirst;
    logic [7:0] srcFirst;
    logic [KW-1:0] ipKey;
    logic [KW-1:0] srcKey;
    logic capturing;

    assign tagBytes = (frameTagCount >= 2'h2) ? 4'(2 * soac_pkg::TAG_BYTES)
        : (frameTagCount == 2'h1) ? 4'(soac_pkg::TAG_BYTES) : 4'h0;
    assign ipFirst = 8'(soac_pkg::IP_START) + 8'(tagBytes);
    assign srcFirst = 8'(soac_pkg::SRC_START) + 8'(tagBytes);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bytePos <= 8'h00;
            capturing <= 1'b0;
            ipKey <= '0;
            srcKey <= '0;
        end else if (frameStart) begin
            bytePos <= 8'h00;
            capturing <= 1'b1;
        end else if (frameByteValid && capturing) begin
            bytePos <= bytePos + 8'h01;
            if (bytePos >= ipFirst && bytePos < ipFirst + 8'(soac_pkg::KEY_BYTES))
                ipKey <= {ipKey[KW-9:0], frameByte};
            if (bytePos >= srcFirst && bytePos < srcFirst + 8'(soac_pkg::KEY_BYTES))
                srcKey <= {srcKey[KW-9:0], frameByte};
            if (bytePos == ipFirst + 8'(soac_pkg::KEY_BYTES - 1))
                capturing <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            keyValid <= 1'b0;
            customKey0 <= '0;
            customKey1 <= '0;
        end else begin
            keyValid <= 1'b0;
            if (frameByteValid && capturing && !frameStart
                && bytePos == ipFirst + 8'(soac_pkg::KEY_BYTES - 1)) begin
                keyValid <= 1'b1;
                customKey0 <= (customKeySelect[1:0] == soac_pkg::KEY_IP)
                    ? {ipKey[KW-9:0], frameByte}
                    : (customKeySelect[1:0] == soac_pkg::KEY_SRC) ? srcKey : '0;
                customKey1 <= (customKeySelect[3:2] == soac_pkg::KEY_IP)
                    ? {ipKey[KW-9:0], frameByte}
                    : (customKeySelect[3:2] == soac_pkg::KEY_SRC) ? srcKey : '0;
            end
        end
    end
endmodule : soac_action_combiner

`default_nettype wire

/* File: soac_checker.sv */
`default_nettype none
module soac_checker (
    // Watched ports
    input wire logic clk,
    input wire logic nrst,
    input wire logic lookupValid,
    input wire logic [2:0] lookupMatch,
    input wire logic [80:0] action0,
    input wire logic [80:0] action2,
    input wire logic [5:0] basicDscp,
    input wire logic [7:0] basicPolicyGroup,
    input wire logic [11:0] basicVid,
    input wire logic classValid,
    input wire logic [5:0] classDscp,
    input wire logic classDropPrec,
    input wire logic [7:0] policyGroup,
    input wire logic [11:0] classVid,
    input wire logic [12:0] srcFilterId,
    input wire logic [12:0] dstFilterId,
    input wire logic keyValid
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_class_pulse: assert property (lookupValid |=> classValid)
        else $error("classValid missing");
    a_no_request: assert property (!lookupValid |=> !classValid)
        else $error("classValid without request");
    a_pass_through: assert property (lookupValid && lookupMatch == 3'h0 |=>
        classDscp == $past(basicDscp) && classVid == $past(basicVid)
        && policyGroup == $past(basicPolicyGroup)) else $error("unmatched changed class");
    a_dscp_first: assert property (lookupValid && lookupMatch == 3'h1 && action0[0] |=>
        classDscp == $past(action0[6:1])) else $error("dscp override wrong");
    a_drop_last: assert property (lookupValid && lookupMatch == 3'h7 && action2[11] |=>
        classDropPrec == $past(action2[12])) else $error("last drop value lost");
    a_pg_merge: assert property (lookupValid && lookupMatch == 3'h1 |=> policyGroup ==
        ($past(basicPolicyGroup) & ~$past(action0[20:13]) | $past(action0[28:21])
        & $past(action0[20:13]))) else $error("policy group merge wrong");
    a_fid_default: assert property (lookupValid && lookupMatch == 3'h0 |=>
        srcFilterId == {1'b0, classVid} && dstFilterId == {1'b0, classVid})
        else $error("default filter id wrong");
    a_fields_hold: assert property (!lookupValid |=> $stable(classDscp)
        && $stable(classVid) && $stable(policyGroup)) else $error("fields moved");
    a_key_pulse: assert property (keyValid |=> !keyValid)
        else $error("keyValid too long");
endmodule : soac_checker
bind soac_action_combiner soac_checker chk (.*);
`default_nettype wire

/* File: soac_frame_source.sv */
`default_nettype none
module soac_frame_source (
    // Control
    input wire logic clk,
    input wire logic go,
    input wire logic [1:0] tags,
    // Frame byte stream
    output logic frameStart,
    output logic frameByteValid,
    output logic [7:0] frameByte,
    output logic [1:0] frameTagCount
);
    timeunit 1ns;
    timeprecision 100ps;
    int pos = 80;
    int tick = 0;
    initial frameStart = 1'b0;
    initial frameByteValid = 1'b0;
    initial frameByte = 8'h00;
    assign frameTagCount = tags;
    // Byte value equals its position; every third cycle stalls
    always @(posedge clk) begin
        tick <= tick + 1;
        frameStart <= go;
        if (pos < 80 && tick % 3 != 0) begin
            frameByteValid <= 1'b1;
            frameByte <= 8'(pos);
            pos <= pos + 1;
        end else begin
            frameByteValid <= 1'b0;
            frameByte <= ~frameByte;
        end
        if (go) pos <= 0;
    end
endmodule : soac_frame_source
`default_nettype wire

/* File: soac_action_combiner_bench.sv */
`default_nettype none
module soac_action_combiner_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, nrst = 0, go = 0, lookupValid = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, classValid, classDropPrec, classDei, keyValid, frameStart;
    logic frameByteValid, basicDropPrec = 0, basicDei = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr, tagPopCount, frameTagCount, tags = 2'h1;
    logic [2:0] lookupMatch = 0, basicClass = 3'h1, basicPcp = 3'h2, classQos, classPcp;
    logic [80:0] action0 = 0, action1 = 0, action2 = 0, ra[4][3];
    logic [5:0] entryIdx0 = 6'h05, entryIdx1 = 6'h21, entryIdx2 = 6'h02;
    logic [5:0] basicDscp = 6'h0A, classDscp;
    logic [7:0] basicPolicyGroup = 8'hF0, policyGroup, frameByte;
    logic [11:0] basicVid = 12'hFFE, classVid;
    logic [12:0] srcFilterId, dstFilterId;
    logic [3:0] customKeySelect;
    logic [319:0] customKey0, customKey1, k0, k1;
    logic [2:0] rm[4];
    logic [66:0] re[4], got;
    int nMismatch = 0, nTests = 0, cyc = 0;
    assign got = {classValid, classDscp, classQos, classDropPrec, policyGroup, classVid,
        classPcp, classDei, srcFilterId, dstFilterId, tagPopCount, customKeySelect};
    soac_action_combiner dut (.*);
    soac_frame_source src (.*);
    initial forever #25 clk = ~clk;
    function automatic logic [80:0] f(int p, int v);
        return 81'(v) << p;
    endfunction : f
    task automatic chk(string n, logic [319:0] e, logic [319:0] g);
        nTests++;
        if (g !== e) begin
            nMismatch++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks %0d mismatches %0d", nTests, nMismatch);
        if (nMismatch == 0 && nTests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            nMismatch++;
            complete_run();
        end
    end
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", 0, s_axi_bresp);
    endtask : wr
    task automatic rdr(logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rdr
    task automatic drv(int i);
        lookupMatch <= rm[i];
        action0 <= ra[i][0];
        action1 <= ra[i][1];
        action2 <= ra[i][2];
        lookupValid <= 1'b1;
    endtask : drv
    task automatic cls(int i, logic [66:0] e);
        @(posedge clk);
        drv(i);
        @(posedge clk);
        lookupValid <= 1'b0;
        #1 chk("class", e, got);
    endtask : cls
    initial begin
        ra[0] = '{'1, '1, '1};
        ra[1] = '{f(0, 1) | f(1, 'h15) | f(7, 1) | f(8, 5) | f(11, 1) | f(12, 1) | f(13, 'h3C)
            | f(21, 'hAA) | f(41, 3) | f(53, 1) | f(55, 'h1234) | f(68, 1) | f(69, 6)
            | f(72, 1) | f(73, 1) | f(74, 2) | f(76, 6), '1, '1};
        ra[2] = '{f(11, 1), f(11, 1) | f(12, 1) | f(40, 1) | f(41, 'h100),
            f(11, 1) | f(41, 5) | f(53, 2) | f(55, 'hAAA) | f(76, 8)};
        ra[3] = '{'1, f(0, 1) | f(1, 'h3F), f(53, 3) | f(55, 9) | f(76, 3)};
        rm = '{3'h0, 3'h1, 3'h7, 3'h6};
        re[0] = {7'h4A, 4'h2, 8'hF0, 12'hFFE, 4'h4, 13'h0FFE, 13'h0FFE, 6'h00};
        re[1] = {7'h55, 4'hB, 8'hE8, 12'h001, 4'hD, 13'h1234, 13'h0001, 6'h26};
        re[2] = {7'h4A, 4'h2, 8'hF0, 12'h105, 4'h4, 13'h0105, 13'h0AAA, 6'h08};
        re[3] = {7'h7F, 4'h2, 8'hF0, 12'hFFE, 4'h4, 13'h0009, 13'h0009, 6'h00};
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i <= 4; i++) begin
            @(posedge clk);
            if (i < 4) drv(i);
            else lookupValid <= 1'b0;
            #1 if (i > 0) chk("class", re[i - 1], got);
        end
        $display("test done: rows");
        rdr(8'h04);
        chk("status", 4, rd);
        rdr(8'h08);
        chk("hit low", 32'h24, rd);
        rdr(8'h0C);
        chk("hit high", 32'h2, rd);
        wr(8'h08, 32'h20);
        rdr(8'h08);
        chk("hit cleared", 32'h4, rd);
        rdr(8'h10);
        chk("unmapped", 2'h2, rr);
        wr(8'h00, 32'h103);
        cls(0, re[0] | 67'h30);
        $display("test done: registers");
        cls(1, re[1]);
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do @(posedge clk); while (keyValid !== 1'b1);
        #1 for (int j = 0; j < 40; j++) begin
            k0[319 - 8 * j -: 8] = 8'(16 + j);
            k1[319 - 8 * j -: 8] = 8'(38 + j);
        end
        chk("source key", k0, customKey0);
        chk("ip key", k1, customKey1);
        @(posedge clk);
        nrst <= 1'b0;
        #1 chk("reset", 0, got);
        $display("test done: custom keys");
        complete_run();
    end
endmodule : soac_action_combiner_bench
`default_nettype wire
